//--- rtl/ctw_pkg.sv
package ctw_pkg;

  // Condition flag bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;

  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h68;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [15:0] INDEX_RST = 16'h0000;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  localparam logic [15:0] PC_RST    = 16'h0000;

  // Opcodes handled here
  localparam logic [7:0] OPC_PREFIX     = 8'h9E;
  localparam logic [7:0] OPC_TEST_DIR   = 8'h3D;
  localparam logic [7:0] OPC_TEST_ACC   = 8'h4D;
  localparam logic [7:0] OPC_TEST_XLO   = 8'h5D;
  localparam logic [7:0] OPC_TEST_IX1   = 8'h6D;
  localparam logic [7:0] OPC_TEST_IX    = 8'h7D;
  localparam logic [7:0] OPC_TEST_SP1   = 8'h6D;
  localparam logic [7:0] OPC_IDX_TO_SP  = 8'h94;
  localparam logic [7:0] OPC_SP_TO_IDX  = 8'h95;
  localparam logic [7:0] OPC_XLO_TO_ACC = 8'h9F;
  localparam logic [7:0] OPC_WAIT       = 8'h8F;
  localparam logic [7:0] OPC_MOV_DD     = 8'h4E;
  localparam logic [7:0] OPC_MOV_DIXP   = 8'h5E;
  localparam logic [7:0] OPC_MOV_IMD    = 8'h6E;
  localparam logic [7:0] OPC_MOV_IXPD   = 8'h7E;
  localparam logic [7:0] OPC_IX1P_FORM  = 8'h61;
  localparam logic [7:0] OPC_IXP_FORM   = 8'h71;

  localparam logic [7:0] DIRECT_PAGE = 8'h00;

  typedef enum logic [3:0] {
    CTW_INHERENT, CTW_DIRECT, CTW_EXTENDED, CTW_IDX_PLAIN, CTW_IDX_POSTINC,
    CTW_IDX_SHORT, CTW_IDX_SHORT_POSTINC, CTW_IDX_LONG, CTW_STK_SHORT,
    CTW_STK_LONG, CTW_MOV_DD, CTW_MOV_IMD, CTW_MOV_IXD, CTW_MOV_DIX, CTW_NONE
  } ctw_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
  } ctw_bus_s;

  typedef struct packed {
    logic [7:0]  opcode;
    logic        prefixed;
    logic [15:0] ea;
    logic [7:0]  data;
  } ctw_operand_s;

endpackage

//--- rtl/ctw_ea_calc.sv
`timescale 1ns/1ps
module ctw_ea_calc
  import ctw_pkg::*;
(
  // Mode and pointers
  input  ctw_mode_e   mode,
  input  wire  [15:0] index_pair,
  input  wire  [15:0] stack_ptr,
  // Operand bytes as fetched
  input  wire  [7:0]  byte1,
  input  wire  [7:0]  byte2,
  // Effective address
  output logic [15:0] ea
);

  always_comb begin
    case (mode)
      CTW_DIRECT:            ea = {DIRECT_PAGE, byte1};
      CTW_EXTENDED:          ea = {byte1, byte2};                         // [RQ15]
      CTW_IDX_PLAIN,
      CTW_IDX_POSTINC:       ea = index_pair;                             // [RQ8] [RQ9]
      CTW_IDX_SHORT,
      CTW_IDX_SHORT_POSTINC: ea = index_pair + {8'h00, byte1};            // [RQ10] [RQ11]
      CTW_IDX_LONG:          ea = index_pair + {byte1, byte2};            // [RQ12]
      CTW_STK_SHORT:         ea = stack_ptr + {8'h00, byte1};             // [RQ13]
      CTW_STK_LONG:          ea = stack_ptr + {byte1, byte2};             // [RQ14]
      default:               ea = index_pair;
    endcase
  end

endmodule // ctw_ea_calc

//--- rtl/ctw_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Test sets N,Z from value, clears V.
// RQ2: Wait clears interrupt mask; one-byte opcode.
// RQ3: After wait, CPU clock stops until interrupt.
// RQ4: SP+1 to index, index-1 to SP, two cycles; core takes three (fetch, decode, transfer).
// RQ5: Index low copied to accumulator, flags kept.
// RQ6: Index pair is high:low sixteen-bit pointer.
// RQ7: Operand field is one or two bytes.
// RQ8: Plain indexed uses index pair, no offset.
// RQ9: Indexed post-increment bumps index after access.
// RQ10: Short indexed adds unsigned byte offset.
// RQ11: Short indexed post-increment adds, then increments.
// RQ12: Long indexed offset fetched high then low.
// RQ13: Stack short adds byte to stack pointer.
// RQ14: Stack long adds word; prefixed opcode.
// RQ15: Extended address fetched high then low.
// RQ16: Direct-to-direct move, both addresses in instruction.
// RQ17: Immediate byte written to direct destination.
// RQ18: Indexed source to direct, then index increments.
// RQ19: Direct source to indexed, then index increments.
module ctw_core
  import ctw_pkg::*;
#(
  parameter logic [15:0] START_PC = PC_RST
)(
  // Clock and reset
  input  wire           ref_clk,
  input  wire           rst_n,
  // Memory port, read data valid while request is up
  input  wire  [7:0]    mem_rdata,
  output ctw_bus_s      mem_req,
  // Interrupt pin, asynchronous
  input  wire           irq_pin,
  // CPU clock gate
  output logic          cpu_run,
  // Architectural state
  output logic [7:0]    acc,
  output logic [15:0]   index_pair,
  output logic [15:0]   stack_ptr,
  output logic [15:0]   prog_ctr,
  output logic [7:0]    condition_flags,
  // Operand hand-off to the rest of the execute path
  output ctw_operand_s  operand,
  output logic          operand_valid,
  output logic          unsupported_op
);

  typedef enum {
    S_FETCH, S_DECODE, S_BYTE1, S_BYTE2, S_READ, S_WRITE, S_XFER, S_HALT
  } ctw_state_e;

  ctw_state_e   state_reg;
  ctw_bus_s     bus_reg;
  ctw_operand_s operand_reg;
  ctw_mode_e    mode_reg;
  logic         run_reg;
  logic         opv_reg;
  logic         unsup_reg;
  logic         prefix_reg;
  logic [7:0]   opcode_reg;
  logic [7:0]   byte1_reg;
  logic [7:0]   byte2_reg;
  logic [7:0]   acc_reg;
  logic [15:0]  hx_reg;
  logic [15:0]  sp_reg;
  logic [15:0]  pc_reg;
  logic [7:0]   flags_reg;
  logic         irq_meta_reg;
  logic         irq_sync_reg;
  logic [15:0]  ea;
  ctw_mode_e    dec_mode;
  logic         is_test;

  ctw_ea_calc u_ea (
    .mode       (mode_reg),
    .index_pair (hx_reg),
    .stack_ptr  (sp_reg),
    .byte1      (byte1_reg),
    .byte2      (byte2_reg),
    .ea         (ea)
  );

  // Interrupt pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_pin;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // Addressing mode from opcode; prefixed page only knows stack forms
  always_comb begin
    dec_mode = CTW_NONE;
    if (prefix_reg) begin
      case (mem_rdata[7:4])
        4'h6, 4'hE: dec_mode = CTW_STK_SHORT;                            // [RQ13]
        4'hD:       dec_mode = CTW_STK_LONG;                             // [RQ14]
        default:    dec_mode = CTW_NONE;
      endcase
    end else begin
      case (mem_rdata)
        OPC_MOV_DD:    dec_mode = CTW_MOV_DD;
        OPC_MOV_DIXP:  dec_mode = CTW_MOV_DIX;
        OPC_MOV_IMD:   dec_mode = CTW_MOV_IMD;
        OPC_MOV_IXPD:  dec_mode = CTW_MOV_IXD;
        OPC_IX1P_FORM: dec_mode = CTW_IDX_SHORT_POSTINC;
        OPC_IXP_FORM:  dec_mode = CTW_IDX_POSTINC;
        OPC_TEST_ACC, OPC_TEST_XLO, OPC_IDX_TO_SP, OPC_SP_TO_IDX,
        OPC_XLO_TO_ACC, OPC_WAIT:
                       dec_mode = CTW_INHERENT;
        default: begin
          case (mem_rdata[7:4])
            4'h3, 4'hB: dec_mode = CTW_DIRECT;
            4'hC:       dec_mode = CTW_EXTENDED;
            4'hD:       dec_mode = CTW_IDX_LONG;
            4'h6, 4'hE: dec_mode = CTW_IDX_SHORT;
            4'h7, 4'hF: dec_mode = CTW_IDX_PLAIN;
            default:    dec_mode = CTW_NONE;
          endcase
        end
      endcase
    end
  end

  // Test forms share one opcode low nibble across their modes
  always_comb begin
    is_test = (opcode_reg == OPC_TEST_DIR) || (opcode_reg == OPC_TEST_IX1)
           || (opcode_reg == OPC_TEST_IX) || (prefix_reg && opcode_reg == OPC_TEST_SP1);
  end

  // Sequencer and memory requests
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= S_FETCH;
      bus_reg    <= '0;
      prefix_reg <= 1'b0;
      opcode_reg <= 8'h00;
      mode_reg   <= CTW_NONE;
      byte1_reg  <= 8'h00;
      byte2_reg  <= 8'h00;
      pc_reg     <= START_PC;
      run_reg    <= 1'b1;
    end else begin
      bus_reg.re <= 1'b0;
      bus_reg.we <= 1'b0;
      case (state_reg)
        S_FETCH: begin
          bus_reg.addr <= pc_reg;
          bus_reg.re   <= 1'b1;
          pc_reg       <= pc_reg + 16'h0001;
          prefix_reg   <= 1'b0;
          state_reg    <= S_DECODE;
        end
        S_DECODE: begin
          opcode_reg <= mem_rdata;
          mode_reg   <= dec_mode;
          if (!prefix_reg && mem_rdata == OPC_PREFIX) begin
            // Second opcode byte of the stack-relative page
            prefix_reg   <= 1'b1;                                         // [RQ14]
            bus_reg.addr <= pc_reg;
            bus_reg.re   <= 1'b1;
            pc_reg       <= pc_reg + 16'h0001;
            state_reg    <= S_DECODE;
          end else begin
            case (dec_mode)
              CTW_INHERENT: begin
                if (mem_rdata == OPC_WAIT) begin
                  run_reg   <= 1'b0;                                      // [RQ3]
                  state_reg <= S_HALT;
                end else if (mem_rdata == OPC_SP_TO_IDX || mem_rdata == OPC_IDX_TO_SP) begin
                  state_reg <= S_XFER;                                    // [RQ4]
                end else begin
                  state_reg <= S_FETCH;
                end
              end
              CTW_IDX_PLAIN, CTW_IDX_POSTINC: begin
                // No offset byte in the stream
                bus_reg.addr <= hx_reg;                                   // [RQ8] [RQ9]
                bus_reg.re   <= 1'b1;
                state_reg    <= S_READ;
              end
              CTW_NONE: state_reg <= S_FETCH;
              default: begin
                bus_reg.addr <= pc_reg;                                   // [RQ7]
                bus_reg.re   <= 1'b1;
                pc_reg       <= pc_reg + 16'h0001;
                state_reg    <= S_BYTE1;
              end
            endcase
          end
        end
        S_BYTE1: begin
          byte1_reg <= mem_rdata;
          case (mode_reg)
            CTW_EXTENDED, CTW_IDX_LONG, CTW_STK_LONG, CTW_MOV_DD, CTW_MOV_IMD: begin
              // Second operand byte; for address and offset words the high byte came first
              bus_reg.addr <= pc_reg;                                     // [RQ7] [RQ12] [RQ15]
              bus_reg.re   <= 1'b1;
              pc_reg       <= pc_reg + 16'h0001;
              state_reg    <= S_BYTE2;
            end
            CTW_MOV_IXD: begin
              bus_reg.addr <= hx_reg;                                     // [RQ18]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            CTW_MOV_DIX, CTW_DIRECT: begin
              bus_reg.addr <= {DIRECT_PAGE, mem_rdata};                   // [RQ19]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            CTW_IDX_SHORT, CTW_IDX_SHORT_POSTINC: begin
              bus_reg.addr <= hx_reg + {8'h00, mem_rdata};                // [RQ10] [RQ11]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            default: begin
              bus_reg.addr <= sp_reg + {8'h00, mem_rdata};                // [RQ13]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
          endcase
        end
        S_BYTE2: begin
          byte2_reg <= mem_rdata;
          case (mode_reg)
            CTW_MOV_DD: begin
              bus_reg.addr <= {DIRECT_PAGE, byte1_reg};                   // [RQ16]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            CTW_MOV_IMD: begin
              bus_reg.addr  <= {DIRECT_PAGE, mem_rdata};                  // [RQ17]
              bus_reg.wdata <= byte1_reg;
              bus_reg.we    <= 1'b1;
              state_reg     <= S_WRITE;
            end
            CTW_EXTENDED: begin
              bus_reg.addr <= {byte1_reg, mem_rdata};                     // [RQ15]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            CTW_IDX_LONG: begin
              bus_reg.addr <= hx_reg + {byte1_reg, mem_rdata};            // [RQ12]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
            default: begin
              bus_reg.addr <= sp_reg + {byte1_reg, mem_rdata};            // [RQ14]
              bus_reg.re   <= 1'b1;
              state_reg    <= S_READ;
            end
          endcase
        end
        S_READ: begin
          case (mode_reg)
            CTW_MOV_DD: begin
              bus_reg.addr  <= {DIRECT_PAGE, byte2_reg};                  // [RQ16]
              bus_reg.wdata <= mem_rdata;
              bus_reg.we    <= 1'b1;
              state_reg     <= S_WRITE;
            end
            CTW_MOV_IXD: begin
              bus_reg.addr  <= {DIRECT_PAGE, byte1_reg};                  // [RQ18]
              bus_reg.wdata <= mem_rdata;
              bus_reg.we    <= 1'b1;
              state_reg     <= S_WRITE;
            end
            CTW_MOV_DIX: begin
              bus_reg.addr  <= hx_reg;                                    // [RQ19]
              bus_reg.wdata <= mem_rdata;
              bus_reg.we    <= 1'b1;
              state_reg     <= S_WRITE;
            end
            default: state_reg <= S_FETCH;
          endcase
        end
        S_WRITE: state_reg <= S_FETCH;
        S_XFER:  state_reg <= S_FETCH;
        S_HALT: begin
          // Only an interrupt restarts the clocked core
          if (irq_sync_reg) begin
            run_reg   <= 1'b1;                                            // [RQ3]
            state_reg <= S_FETCH;
          end
        end
        default: state_reg <= S_FETCH;
      endcase
    end
  end

  // Index pair and stack pointer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hx_reg <= INDEX_RST;
      sp_reg <= SP_RST;
    end else if (state_reg == S_XFER) begin
      if (opcode_reg == OPC_SP_TO_IDX) begin
        hx_reg <= sp_reg + 16'h0001;                                      // [RQ4] [RQ6]
      end else begin
        sp_reg <= hx_reg - 16'h0001;                                      // [RQ4]
      end
    end else if (state_reg == S_READ && (mode_reg == CTW_IDX_POSTINC
                 || mode_reg == CTW_IDX_SHORT_POSTINC)) begin
      // Bump only after the operand access has gone out
      hx_reg <= hx_reg + 16'h0001;                                        // [RQ9] [RQ11]
    end else if (state_reg == S_WRITE && (mode_reg == CTW_MOV_IXD
                 || mode_reg == CTW_MOV_DIX)) begin
      hx_reg <= hx_reg + 16'h0001;                                        // [RQ18] [RQ19]
    end
  end

  // Accumulator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= ACC_RST;
    end else if (state_reg == S_DECODE && !prefix_reg && mem_rdata == OPC_XLO_TO_ACC) begin
      acc_reg <= hx_reg[7:0];                                             // [RQ5]
    end
  end

  // Condition flags; test leaves the tested value untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_RST;
    end else if (state_reg == S_DECODE && !prefix_reg && mem_rdata == OPC_TEST_ACC) begin
      flags_reg[FLG_V] <= 1'b0;                                           // [RQ1]
      flags_reg[FLG_N] <= acc_reg[7];
      flags_reg[FLG_Z] <= (acc_reg == 8'h00);
    end else if (state_reg == S_DECODE && !prefix_reg && mem_rdata == OPC_TEST_XLO) begin
      flags_reg[FLG_V] <= 1'b0;                                           // [RQ1]
      flags_reg[FLG_N] <= hx_reg[7];
      flags_reg[FLG_Z] <= (hx_reg[7:0] == 8'h00);
    end else if (state_reg == S_DECODE && !prefix_reg && mem_rdata == OPC_WAIT) begin
      flags_reg[FLG_I] <= 1'b0;                                           // [RQ2]
    end else if (state_reg == S_READ && is_test) begin
      flags_reg[FLG_V] <= 1'b0;                                           // [RQ1]
      flags_reg[FLG_N] <= mem_rdata[7];
      flags_reg[FLG_Z] <= (mem_rdata == 8'h00);
    end
  end

  // Operand hand-off for forms executed elsewhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_reg <= '0;
      opv_reg     <= 1'b0;
      unsup_reg   <= 1'b0;
    end else begin
      opv_reg   <= 1'b0;
      unsup_reg <= 1'b0;
      if (state_reg == S_READ && !is_test && (mode_reg != CTW_MOV_DD)
          && (mode_reg != CTW_MOV_IXD) && (mode_reg != CTW_MOV_DIX)) begin
        operand_reg.opcode   <= opcode_reg;
        operand_reg.prefixed <= prefix_reg;
        operand_reg.ea       <= ea;
        operand_reg.data     <= mem_rdata;
        opv_reg              <= 1'b1;
      end
      if (state_reg == S_DECODE && dec_mode == CTW_NONE
          && !(!prefix_reg && mem_rdata == OPC_PREFIX)) begin
        unsup_reg <= 1'b1;
      end
    end
  end

  assign mem_req         = bus_reg;
  assign cpu_run         = run_reg;
  assign acc             = acc_reg;
  assign index_pair      = hx_reg;
  assign stack_ptr       = sp_reg;
  assign prog_ctr        = pc_reg;
  assign condition_flags = flags_reg;
  assign operand         = operand_reg;
  assign operand_valid   = opv_reg;
  assign unsupported_op  = unsup_reg;

endmodule // ctw_core

//--- testbench/ctw_core_props.sv
`timescale 1ns/1ps
module ctw_core_props
  import ctw_pkg::*;
(
  // Clock and reset
  input wire          ref_clk,
  input wire          rst_n,
  // Watched ports
  input wire          irq_pin,
  input wire          cpu_run,
  input ctw_bus_s     mem_req,
  input wire [7:0]    mem_rdata,
  input wire [7:0]    acc,
  input wire [15:0]   index_pair,
  input wire [15:0]   stack_ptr,
  input wire [7:0]    condition_flags,
  input ctw_operand_s operand,
  input wire          operand_valid,
  input wire          unsupported_op
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  halt_quiet_a: assert property (!cpu_run && !$past(cpu_run) |-> !mem_req.re && !mem_req.we)
    else $error("bus active while halted");
  halt_holds_a: assert property ((!irq_pin) [*4] ##0 !cpu_run |=> !cpu_run)
    else $error("resumed without interrupt");
  wake_bound_a: assert property (!cpu_run && irq_pin |-> ##[1:4] cpu_run)
    else $error("no resume after interrupt");
  wait_mask_a: assert property ($fell(cpu_run) |-> !condition_flags[FLG_I])
    else $error("mask still set on halt");
  sp_flags_a: assert property (stack_ptr != $past(stack_ptr) |-> condition_flags == $past(condition_flags))
    else $error("flags moved with stack pointer");
  acc_copy_a: assert property (acc != $past(acc) |-> acc == index_pair[7:0] && condition_flags == $past(condition_flags))
    else $error("accumulator change not a clean copy");
  operand_src_a: assert property (operand_valid |-> $past(mem_req.re) && operand.ea == $past(mem_req.addr) && operand.data == $past(mem_rdata))
    else $error("operand not from last read");
  plain_ea_a: assert property (operand_valid && !operand.prefixed && operand.opcode[7:4] == 4'hF |-> operand.ea == index_pair)
    else $error("plain indexed address wrong");
  postinc_a: assert property (operand_valid && !operand.prefixed && operand.opcode == OPC_IXP_FORM |-> index_pair == operand.ea + 16'h0001)
    else $error("post increment wrong");
  short_postinc_a: assert property (operand_valid && !operand.prefixed && operand.opcode == OPC_IX1P_FORM |-> index_pair == $past(index_pair) + 16'h0001)
    else $error("short post increment wrong");
  single_pulse_a: assert property (operand_valid || unsupported_op |=> !operand_valid && !unsupported_op)
    else $error("pulse longer than one cycle");
endmodule // ctw_core_props

bind ctw_core ctw_core_props i_props (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .irq_pin(irq_pin),
  .cpu_run(cpu_run),
  .mem_req(mem_req),
  .mem_rdata(mem_rdata),
  .acc(acc),
  .index_pair(index_pair),
  .stack_ptr(stack_ptr),
  .condition_flags(condition_flags),
  .operand(operand),
  .operand_valid(operand_valid),
  .unsupported_op(unsupported_op)
);

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import ctw_pkg::*;
;
  logic         ref_clk;
  logic         rst_n;
  logic         irq_pin;
  logic [7:0]   mem_rdata;
  ctw_bus_s     mem_req;
  logic         cpu_run;
  logic [7:0]   acc;
  logic [15:0]  index_pair;
  logic [15:0]  stack_ptr;
  logic [15:0]  prog_ctr;
  logic [7:0]   condition_flags;
  ctw_operand_s operand;
  logic         operand_valid;
  logic         unsupported_op;
  logic [7:0]   mem [0:65535];
  logic [7:0]   prog [$];
  logic [15:0]  exp_q [$];
  ctw_operand_s seen_q [$];
  logic [7:0]   flags_m;
  logic [7:0]   ii;
  logic [7:0]   b1;
  logic [7:0]   b2;
  logic [7:0]   b3;
  logic [15:0]  w1;
  logic [15:0]  w2;
  logic [15:0]  w3;
  int           fail_count;
  int           n_checks;
  int           cycles;
  int           n_unsup;
  int           seed;

  // Zero-latency memory, as the core expects
  assign mem_rdata = mem[mem_req.addr];

  ctw_core #(.START_PC(16'h0400)) i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mem_rdata(mem_rdata),
    .mem_req(mem_req),
    .irq_pin(irq_pin),
    .cpu_run(cpu_run),
    .acc(acc),
    .index_pair(index_pair),
    .stack_ptr(stack_ptr),
    .prog_ctr(prog_ctr),
    .condition_flags(condition_flags),
    .operand(operand),
    .operand_valid(operand_valid),
    .unsupported_op(unsupported_op)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] tst_flags(input logic [7:0] f, input logic [7:0] v);
    tst_flags = f;
    tst_flags[FLG_V] = 1'b0;
    tst_flags[FLG_N] = v[7];
    tst_flags[FLG_Z] = (v == 8'h00);
  endfunction

  always @(posedge ref_clk) begin
    if (mem_req.we === 1'b1)
      mem[mem_req.addr] <= mem_req.wdata;
    if (operand_valid === 1'b1)
      seen_q.push_back(operand);
    if (unsupported_op === 1'b1)
      n_unsup++;
    cycles++;
    // Whole program needs well under a thousand cycles
    if (cycles > 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic halt();
    int k;
    logic [15:0] e;
    ctw_operand_s s;
    k = 0;
    while (cpu_run !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    flags_m[FLG_I] = 1'b0;
    check("halted", 16'h0000, 16'(cpu_run));
    check("flags", 16'(flags_m), 16'(condition_flags));
    check("operand count", 16'(exp_q.size()), 16'(seen_q.size()));
    while (seen_q.size() > 0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      s = seen_q.pop_front();
      check("operand ea", e, s.ea);
      check("operand data", 16'(mem[e]), 16'(s.data));
    end
    seen_q.delete();
    exp_q.delete();
  endtask

  task automatic wake();
    int k;
    k = {$random(seed)} % 6;
    repeat (k) @(negedge ref_clk);
    check("still halted", 16'h0000, 16'(cpu_run));
    @(posedge ref_clk);
    irq_pin <= 1'b1;
    k = 0;
    while (cpu_run !== 1'b1 && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
    check("resumed", 16'h0001, 16'(cpu_run));
    @(posedge ref_clk);
    irq_pin <= 1'b0;
  endtask

  initial begin
    seed = 85236;
    rst_n = 1'b0;
    irq_pin = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    n_unsup = 0;
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'($random(seed));
    ii = 8'($random(seed));
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    b3 = 8'($random(seed));
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    w3 = 16'($random(seed));
    mem[16'h0002] = 8'h80;
    // Segments end in a wait so each result can be read while halted
    prog = {OPC_IDX_TO_SP, OPC_SP_TO_IDX, OPC_WAIT,
            OPC_IXP_FORM, OPC_IX1P_FORM, b1, OPC_XLO_TO_ACC, OPC_TEST_ACC, OPC_TEST_IX, OPC_WAIT,
            OPC_MOV_IMD, ii, 8'h10, OPC_MOV_DD, 8'h10, 8'h20, OPC_MOV_IXPD, 8'h30,
            OPC_MOV_DIXP, 8'h20, OPC_TEST_DIR, 8'h20, OPC_WAIT,
            8'hC6, w1[15:8], w1[7:0], 8'hD6, w2[15:8], w2[7:0], 8'hE6, b2, 8'hF6,
            OPC_PREFIX, 8'hE6, b3, OPC_PREFIX, 8'hD6, w3[15:8], w3[7:0], OPC_PREFIX, 8'h6D, b3,
            OPC_PREFIX, 8'h00, OPC_WAIT};
    foreach (prog[i])
      mem[16'h0400 + 16'(i)] = prog[i];
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    flags_m = FLAGS_RST;
    halt();
    check("sp", 16'hFFFF, stack_ptr);
    check("index", 16'h0000, index_pair);
    check("pc", 16'h0403, prog_ctr);
    wake();
    flags_m = tst_flags(flags_m, 8'h80);
    exp_q = {16'h0000, 16'h0001 + {8'h00, b1}};
    halt();
    check("index", 16'h0002, index_pair);
    check("acc", 16'h0002, 16'(acc));
    wake();
    flags_m = tst_flags(flags_m, ii);
    halt();
    check("imm move", 16'(ii), 16'(mem[16'h0010]));
    check("dir move", 16'(ii), 16'(mem[16'h0020]));
    check("idx move", 16'h0080, 16'(mem[16'h0030]));
    check("to idx move", 16'(ii), 16'(mem[16'h0003]));
    check("index", 16'h0004, index_pair);
    wake();
    exp_q = {w1, 16'h0004 + w2, 16'h0004 + {8'h00, b2}, 16'h0004,
             16'hFFFF + {8'h00, b3}, 16'hFFFF + w3};
    // Stack-relative test reads low memory, final after the move segment
    flags_m = tst_flags(flags_m, mem[16'hFFFF + {8'h00, b3}]);
    halt();
    check("unsupported", 16'h0001, 16'(n_unsup));
    print_verdict();
  end
endmodule // testbench
